// ===== hw/fws_pkg.sv
package fws_pkg;
    // Software register map of the controller.
    localparam logic [7:0] REG_ADDR = 8'h00;
    localparam logic [7:0] REG_WDATA = 8'h04;
    localparam logic [7:0] REG_CTRL = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA = 8'h10;

    localparam int CTRL_ABORT_BIT = 3;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_OK_BIT = 2;
    localparam int STAT_FAIL_BIT = 3;
    localparam int STAT_RST_BIT = 4;
    localparam int STAT_WIN_BIT = 5;

    localparam logic [2:0] CMD_WRITE = 3'h1;
    localparam logic [2:0] CMD_READ = 3'h2;
    localparam logic [2:0] CMD_TOGGLE = 3'h3;
    localparam logic [2:0] CMD_POLL = 3'h4;

    localparam logic [7:0] RESET_CMD = 8'hF0;

    // Status bit positions on the flash data lines.
    localparam int POLL_BIT = 7;
    localparam int TOGGLE_BIT = 6;
    localparam int FAIL_BIT = 5;
    localparam int WINDOW_BIT = 3;

    localparam logic [1:0] PH_FIRST = 2'h0;
    localparam logic [1:0] PH_SECOND = 2'h1;
    localparam logic [1:0] PH_RECHECK = 2'h2;

    localparam int CLK_PERIOD_NS = 100;
    localparam int T_STROBE_NS = 150;
    localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] STROBE_LAST = 2'(STROBE_CYC - 1);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_STROBE = 3'b010,
        ST_HOLD = 3'b011,
        ST_DECIDE = 3'b100
    } fws_state_e;

    typedef struct packed {
        logic [16:0] addr;
        logic [7:0] dq_o;
        logic dq_oe;
        logic ce_n;
        logic oe_n;
        logic we_n;
    } fws_pins_s;

    localparam fws_pins_s PINS_IDLE = '{addr: 17'h00000, dq_o: 8'h00, dq_oe: 1'b0,
                                        ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
endpackage

// ===== hw/fws_host.sv
// Implementation choices: the strobed register port and the register addresses.
module fws_host
    import fws_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [7:0] bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [31:0] bus_rdata,
    output fws_pins_s flash_pins,
    input wire logic [7:0] flash_dq_i
);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    fws_state_e state_r, state_nxt;
    fws_pins_s pins_r, pins_nxt;
    logic [2:0] cmd_r, cmd_nxt;
    logic [1:0] phase_r, phase_nxt;
    logic [1:0] cnt_r, cnt_nxt;
    logic is_wr_r, is_wr_nxt;
    logic rst_pend_r, rst_pend_nxt;
    logic [7:0] samp_r, samp_nxt;
    logic [7:0] first_r, first_nxt;
    logic [16:0] addr_r, addr_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic busy_r, busy_nxt;
    logic done_r, done_nxt;
    logic ok_r, ok_nxt;
    logic fail_r, fail_nxt;
    logic rst_issued_r, rst_issued_nxt;
    logic win_r, win_nxt;
    logic abort_r, abort_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [31:0] status_word;
    logic start;
    logic tog_same;
    logic poll_match;

    assign start = bus_wr && hit(bus_addr, REG_CTRL) && !busy_r &&
                   (bus_wdata[2:0] >= CMD_WRITE) && (bus_wdata[2:0] <= CMD_POLL);
    assign tog_same = (samp_r[TOGGLE_BIT] == first_r[TOGGLE_BIT]);
    assign poll_match = (samp_r[POLL_BIT] == wdata_r[POLL_BIT]);

    always_comb begin
        status_word = 32'h00000000;
        status_word[STAT_BUSY_BIT] = busy_r;
        status_word[STAT_DONE_BIT] = done_r;
        status_word[STAT_OK_BIT] = ok_r;
        status_word[STAT_FAIL_BIT] = fail_r;
        status_word[STAT_RST_BIT] = rst_issued_r;
        status_word[STAT_WIN_BIT] = win_r;
    end

    always_comb begin
        state_nxt = state_r;
        cmd_nxt = cmd_r;
        phase_nxt = phase_r;
        cnt_nxt = cnt_r;
        is_wr_nxt = is_wr_r;
        rst_pend_nxt = rst_pend_r;
        samp_nxt = samp_r;
        first_nxt = first_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        busy_nxt = busy_r;
        done_nxt = done_r;
        ok_nxt = ok_r;
        fail_nxt = fail_r;
        rst_issued_nxt = rst_issued_r;
        win_nxt = win_r;
        abort_nxt = abort_r;
        rdata_nxt = 32'h00000000;

        if (bus_rd) begin
            if (hit(bus_addr, REG_ADDR)) begin
                rdata_nxt = {15'h0000, addr_r};
            end else if (hit(bus_addr, REG_WDATA)) begin
                rdata_nxt = {24'h000000, wdata_r};
            end else if (hit(bus_addr, REG_STATUS)) begin
                rdata_nxt = status_word;
            end else if (hit(bus_addr, REG_RDATA)) begin
                rdata_nxt = {24'h000000, samp_r};
            end
        end
        // Address and data are frozen while a sequence runs.
        if (bus_wr && !busy_r && hit(bus_addr, REG_ADDR)) begin
            addr_nxt = bus_wdata[16:0];
        end
        if (bus_wr && !busy_r && hit(bus_addr, REG_WDATA)) begin
            wdata_nxt = bus_wdata[7:0];
        end
        if (bus_wr && busy_r && hit(bus_addr, REG_CTRL) && bus_wdata[CTRL_ABORT_BIT]) begin
            abort_nxt = 1'b1;
        end

        case (state_r)
            ST_IDLE: begin
                if (start) begin
                    cmd_nxt = bus_wdata[2:0];
                    is_wr_nxt = (bus_wdata[2:0] == CMD_WRITE);
                    phase_nxt = PH_FIRST;
                    rst_pend_nxt = 1'b0;
                    busy_nxt = 1'b1;
                    done_nxt = 1'b0;
                    ok_nxt = 1'b0;
                    fail_nxt = 1'b0;
                    rst_issued_nxt = 1'b0;
                    abort_nxt = 1'b0;
                    state_nxt = ST_SETUP;
                end
            end
            ST_SETUP: begin
                cnt_nxt = 2'h0;
                state_nxt = ST_STROBE;
            end
            ST_STROBE: begin
                cnt_nxt = cnt_r + 2'h1;
                if (cnt_r == STROBE_LAST) begin
                    if (!is_wr_r) begin
                        samp_nxt = flash_dq_i;
                        win_nxt = flash_dq_i[WINDOW_BIT];
                    end
                    state_nxt = ST_HOLD;
                end
            end
            ST_HOLD: begin
                state_nxt = ST_DECIDE;
            end
            ST_DECIDE: begin
                state_nxt = ST_IDLE;
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
                if (rst_pend_r) begin
                    fail_nxt = 1'b1;
                    rst_issued_nxt = 1'b1;
                end else if (cmd_r == CMD_WRITE || cmd_r == CMD_READ) begin
                    ok_nxt = 1'b1;
                end else begin
                    // An unresolved outcome below starts another read cycle, or the reset write cycle on a failure, unless a pending abort ends it when the next phase is PH_FIRST.
                    busy_nxt = 1'b1;
                    done_nxt = 1'b0;
                    state_nxt = ST_SETUP;
                    if (cmd_r == CMD_TOGGLE && phase_r == PH_FIRST) begin
                        first_nxt = samp_r;
                        phase_nxt = PH_SECOND;
                    end else if (cmd_r == CMD_TOGGLE && phase_r == PH_SECOND) begin
                        if (tog_same) begin
                            ok_nxt = 1'b1;
                        end else if (samp_r[FAIL_BIT]) begin
                            first_nxt = samp_r;
                            phase_nxt = PH_RECHECK;
                        end else begin
                            phase_nxt = PH_FIRST;
                        end
                    end else if (cmd_r == CMD_TOGGLE) begin
                        if (tog_same) begin
                            ok_nxt = 1'b1;
                        end else begin
                            rst_pend_nxt = 1'b1;
                        end
                    end else if (phase_r == PH_FIRST) begin
                        if (poll_match) begin
                            ok_nxt = 1'b1;
                        end else if (samp_r[FAIL_BIT]) begin
                            phase_nxt = PH_RECHECK;
                        end
                    end else begin
                        if (poll_match) begin
                            ok_nxt = 1'b1;
                        end else begin
                            rst_pend_nxt = 1'b1;
                        end
                    end
                    if (ok_nxt) begin
                        state_nxt = ST_IDLE;
                        busy_nxt = 1'b0;
                        done_nxt = 1'b1;
                    end else if (rst_pend_nxt) begin
                        is_wr_nxt = 1'b1;
                    end else if (abort_r && phase_nxt == PH_FIRST) begin
                        // Aborted checks end with done set and neither ok nor fail.
                        state_nxt = ST_IDLE;
                        busy_nxt = 1'b0;
                        done_nxt = 1'b1;
                    end
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase

        pins_nxt = PINS_IDLE;
        pins_nxt.addr = addr_nxt;
        if (state_nxt == ST_SETUP || state_nxt == ST_STROBE || state_nxt == ST_HOLD) begin
            pins_nxt.dq_oe = is_wr_nxt;
            pins_nxt.dq_o = rst_pend_nxt ? RESET_CMD : wdata_nxt;
        end
        if (state_nxt == ST_SETUP || state_nxt == ST_STROBE) begin
            pins_nxt.ce_n = 1'b0;
        end
        if (state_nxt == ST_STROBE) begin
            pins_nxt.we_n = !is_wr_nxt;
            pins_nxt.oe_n = is_wr_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            pins_r <= PINS_IDLE;
            cmd_r <= 3'h0;
            phase_r <= PH_FIRST;
            cnt_r <= 2'h0;
            is_wr_r <= 1'b0;
            rst_pend_r <= 1'b0;
            samp_r <= 8'h00;
            first_r <= 8'h00;
            addr_r <= 17'h00000;
            wdata_r <= 8'h00;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            ok_r <= 1'b0;
            fail_r <= 1'b0;
            rst_issued_r <= 1'b0;
            win_r <= 1'b0;
            abort_r <= 1'b0;
            rdata_r <= 32'h00000000;
        end else begin
            state_r <= state_nxt;
            pins_r <= pins_nxt;
            cmd_r <= cmd_nxt;
            phase_r <= phase_nxt;
            cnt_r <= cnt_nxt;
            is_wr_r <= is_wr_nxt;
            rst_pend_r <= rst_pend_nxt;
            samp_r <= samp_nxt;
            first_r <= first_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            ok_r <= ok_nxt;
            fail_r <= fail_nxt;
            rst_issued_r <= rst_issued_nxt;
            win_r <= win_nxt;
            abort_r <= abort_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign bus_rdata = rdata_r;
    assign flash_pins = pins_r;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    logic dec_tog2, dec_tog3, dec_poll1;
    assign dec_tog2 = (state_r == ST_DECIDE) && (cmd_r == CMD_TOGGLE) && (phase_r == PH_SECOND) && !rst_pend_r;
    assign dec_tog3 = (state_r == ST_DECIDE) && (cmd_r == CMD_TOGGLE) && (phase_r == PH_RECHECK) && !rst_pend_r;
    assign dec_poll1 = (state_r == ST_DECIDE) && (cmd_r == CMD_POLL) && (phase_r == PH_FIRST) && !rst_pend_r;

    sequence reset_setup_s;
        state_r == ST_SETUP && rst_pend_r && pins_r.dq_oe && pins_r.dq_o == RESET_CMD;
    endsequence
    sequence write_pulse_s;
        !pins_r.we_n [*2] ##1 pins_r.we_n;
    endsequence

    chk_toggle_pair_ok: assert property (dec_tog2 && tog_same |=> state_r == ST_IDLE && ok_r && done_r)
        else $error("toggle pair equal but not reported ok");
    chk_toggle_fail_recheck: assert property (dec_tog2 && !tog_same && samp_r[FAIL_BIT]
        |=> phase_r == PH_RECHECK && state_r == ST_SETUP && first_r == $past(samp_r))
        else $error("fail bit high without toggle recheck");
    chk_toggle_restart: assert property (dec_tog2 && !tog_same && !samp_r[FAIL_BIT] && !abort_r
        |=> phase_r == PH_FIRST && state_r == ST_SETUP)
        else $error("toggle monitoring did not restart from the pair");
    chk_fail_resets: assert property ((dec_tog3 && !tog_same) || (state_r == ST_DECIDE && cmd_r == CMD_POLL
        && phase_r == PH_RECHECK && !rst_pend_r && !poll_match) |=> reset_setup_s)
        else $error("failure not followed by reset command");
    chk_reset_cycle: assert property (reset_setup_s |=> write_pulse_s ##2 fail_r && rst_issued_r && !busy_r)
        else $error("reset command write cycle malformed");
    chk_poll_recheck: assert property (dec_poll1 && !poll_match && samp_r[FAIL_BIT]
        |=> phase_r == PH_RECHECK ##1 !pins_r.ce_n ##1 !pins_r.oe_n)
        else $error("poll bit not reread after fail bit");
    chk_poll_address: assert property (busy_r && cmd_r == CMD_POLL && !pins_r.oe_n
        |-> pins_r.addr == addr_r && !pins_r.dq_oe)
        else $error("poll read not at the given address");
    chk_read_cycles: assert property (!pins_r.oe_n && $past(state_r) == ST_SETUP
        |-> !pins_r.oe_n [*2] ##1 (pins_r.oe_n && pins_r.ce_n))
        else $error("read strobe not framed per cycle");
    chk_window_report: assert property (state_r == ST_STROBE && cnt_r == STROBE_LAST && !is_wr_r
        |=> win_r == $past(flash_dq_i[WINDOW_BIT]) && status_word[STAT_WIN_BIT] == win_r)
        else $error("window bit not reported from the read");
    chk_strobe_exclusive: assert property (!(pins_r.oe_n == 1'b0 && pins_r.we_n == 1'b0))
        else $error("both strobes active");

endmodule

// ===== verif/fws_flash_model.sv
module fws_flash_model
    import fws_pkg::*;
(
    input wire fws_pins_s pins,
    input wire logic [7:0] dq_wire,
    input wire logic arm,
    input wire logic [7:0] arm_reads,
    input wire logic arm_fail,
    input wire logic arm_erase,
    input wire logic [7:0] arm_data,
    output logic [7:0] dq_m,
    output logic [7:0] last_wr,
    output int n_resets
);
    timeunit 1ns;
    timeprecision 1ns;
    logic busy = 1'b0;
    logic fail = 1'b0;
    logic erase = 1'b0;
    logic tog = 1'b0;
    logic win = 1'b0;
    logic susp = 1'b0;
    logic chip = 1'b0;
    logic [7:0] left = 8'h00;
    logic [7:0] arr = 8'h00;
    logic [7:0] prog = 8'h00;
    logic [7:0] last = 8'h00;
    logic [7:0] stat;
    wire logic rd_act = !pins.ce_n && !pins.oe_n;
    wire logic wr_act = !pins.ce_n && !pins.we_n;

    initial begin
        n_resets = 0;
    end

    // Status byte of a running algorithm; a suspended sector shows poll one, a steady toggle and no failure.
    assign stat = susp ? {1'h1, tog, 1'h0, 5'h00} :
                  {erase ? 1'h0 : ~prog[POLL_BIT], tog, fail, 1'h0, win, 3'h0};
    // Outside a read the lines show the inverse of the last value, so a stale sample cannot pass.
    assign dq_m = rd_act ? (busy ? stat : arr) : ~last;

    // A test arms an algorithm that runs for a given number of reads, or fails until a reset command.
    always @(posedge arm) begin
        left = arm_reads;
        fail = arm_fail;
        erase = arm_erase;
        prog = arm_data;
        tog = 1'b0;
        win = 1'b0;
        // For an erase, data bit 0 selects a chip erase and bit 1 a suspended sector.
        chip = arm_erase && arm_data[0];
        susp = arm_erase && arm_data[1];
        arr = arm_erase ? 8'hFF : arm_data;
        busy = (arm_reads != 8'h00) || arm_fail;
    end

    always @(negedge rd_act) begin
        last = busy ? stat : arr;
        if (busy && !susp) begin
            tog = ~tog;
            // The sector erase time-out is taken to expire at the first read after the command.
            win = erase && !chip;
            if (!fail) begin
                left = left - 8'h01;
                busy = (left != 8'h00);
            end
        end
    end

    always @(negedge wr_act) begin
        last_wr = dq_wire;
        if (dq_wire == RESET_CMD) begin
            busy = 1'b0;
            fail = 1'b0;
            n_resets++;
        end else if (!busy) begin
            arr = dq_wire;
        end
    end
endmodule

// ===== verif/flash_write_status_reporting_tb.sv
module flash_write_status_reporting_tb import fws_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] S_OK = 32'((1 << STAT_DONE_BIT) | (1 << STAT_OK_BIT));
    localparam logic [31:0] S_FAIL = 32'((1 << STAT_DONE_BIT) | (1 << STAT_FAIL_BIT) | (1 << STAT_RST_BIT));
    localparam logic [31:0] S_WIN = 32'(1 << STAT_WIN_BIT);
    localparam logic [31:0] S_ABORT = 32'(1 << STAT_DONE_BIT);
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [7:0] bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h0;
    logic [31:0] bus_rdata;
    logic [31:0] rv;
    fws_pins_s pins;
    logic [7:0] dq_wire;
    logic [7:0] dq_m;
    logic [7:0] last_wr;
    logic arm = 1'b0;
    logic arm_fail = 1'b0;
    logic arm_erase = 1'b0;
    logic [7:0] arm_reads = 8'h00;
    logic [7:0] arm_data = 8'h00;
    int n_resets;
    int err_count = 0;
    int n_checks = 0;

    assign dq_wire = pins.dq_oe ? pins.dq_o : dq_m;

    fws_host dut (.ref_clk(ref_clk), .resetn(resetn), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .flash_pins(pins), .flash_dq_i(dq_wire));
    fws_flash_model fm (.pins(pins), .dq_wire(dq_wire), .arm(arm), .arm_reads(arm_reads), .arm_fail(arm_fail),
        .arm_erase(arm_erase), .arm_data(arm_data), .dq_m(dq_m), .last_wr(last_wr), .n_resets(n_resets));

    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t ns: seen %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge ref_clk);
        bus_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge ref_clk);
        bus_rd <= 1'b0;
        #1;
        rv = bus_rdata;
    endtask

    // Polls the status register until the controller is idle; the count bounds a hang.
    task automatic wait_idle();
        rv = 32'h1;
        for (int i = 0; i < 400 && rv[STAT_BUSY_BIT] !== 1'b0; i++) begin
            rd(REG_STATUS);
        end
    endtask

    task automatic run(input logic [2:0] cmd);
        wr(REG_CTRL, {29'h0, cmd});
        wait_idle();
    endtask

    task automatic load(input logic [7:0] n, input logic f, input logic e, input logic [7:0] d);
        @(posedge ref_clk);
        arm_reads <= n;
        arm_fail <= f;
        arm_erase <= e;
        arm_data <= d;
        arm <= 1'b1;
        @(posedge ref_clk);
        arm <= 1'b0;
    endtask

    task automatic done_t(input string n);
        $display("Test %s finished, mismatches so far %0d", n, err_count);
    endtask

    task automatic close_out();
        $display("Checks made %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge ref_clk);
        err_count++;
        close_out();
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(REG_STATUS);
        check(rv, 32'h0);
        rd(8'h14);
        check(rv, 32'h0);
        check({31'h0, pins.ce_n}, 32'h1);
        done_t("reset");
        wr(REG_ADDR, 32'h1ABCD);
        wr(REG_WDATA, 32'hA5);
        run(CMD_WRITE);
        check(rv, S_OK);
        check({24'h0, last_wr}, 32'hA5);
        done_t("write");
        load(8'h00, 1'b0, 1'b0, 8'h5C);
        run(CMD_READ);
        check(rv, S_OK | S_WIN);
        rd(REG_RDATA);
        check(rv, 32'h5C);
        done_t("read");
        load(8'h06, 1'b0, 1'b0, 8'h11);
        run(CMD_TOGGLE);
        check(rv, S_OK);
        check(n_resets, 0);
        done_t("toggle ok");
        load(8'h00, 1'b1, 1'b0, 8'h11);
        run(CMD_TOGGLE);
        check(rv, S_FAIL);
        check(n_resets, 1);
        check({24'h0, last_wr}, {24'h0, RESET_CMD});
        run(CMD_READ);
        rd(REG_RDATA);
        check(rv, 32'h11);
        done_t("toggle fail");
        wr(REG_WDATA, 32'h91);
        load(8'h04, 1'b0, 1'b0, 8'h91);
        run(CMD_POLL);
        check(rv, S_OK);
        done_t("poll program");
        load(8'h03, 1'b0, 1'b1, 8'h00);
        run(CMD_READ);
        rd(REG_RDATA);
        check(rv, 32'h00);
        run(CMD_READ);
        rd(REG_RDATA);
        check(rv, 32'h48);
        wr(REG_WDATA, 32'h80);
        load(8'h05, 1'b0, 1'b1, 8'h00);
        run(CMD_POLL);
        check(rv, S_OK | S_WIN);
        done_t("poll erase");
        load(8'h02, 1'b0, 1'b1, 8'h01);
        run(CMD_READ);
        run(CMD_READ);
        check(rv, S_OK);
        rd(REG_RDATA);
        check(rv, 32'h40);
        done_t("chip erase");
        load(8'h02, 1'b0, 1'b1, 8'h02);
        run(CMD_TOGGLE);
        check(rv, S_OK);
        rd(REG_RDATA);
        check(rv, 32'h80);
        done_t("suspend");
        wr(REG_WDATA, 32'h91);
        load(8'h00, 1'b1, 1'b0, 8'h91);
        run(CMD_POLL);
        check(rv, S_FAIL);
        check(n_resets, 2);
        done_t("poll fail");
        load(8'hC8, 1'b0, 1'b0, 8'h11);
        wr(REG_CTRL, {29'h0, CMD_TOGGLE});
        wr(REG_ADDR, 32'h00055);
        wr(REG_CTRL, 32'(1 << CTRL_ABORT_BIT));
        wait_idle();
        check(rv, S_ABORT);
        rd(REG_ADDR);
        check(rv, 32'h1ABCD);
        check({15'h0, pins.addr}, 32'h1ABCD);
        wr(REG_CTRL, 32'h0);
        rd(REG_STATUS);
        check(rv, S_ABORT);
        done_t("abort");
        close_out();
    end
endmodule
